// file: blcb_config_bank.v
/*
  Backlight configuration bank: two configuration bytes and the control
  outputs derived from them.
  Assumes a serial slave front end on sys_clk presents decoded byte writes
  and reads (wrEn/rdEn with addr and data), and that the stored frequency
  codes are on sys_clk; the frequency-select pin is asynchronous and is
  synchronised here, so pin changes reach the outputs three edges later.
*/
// How it works
// R01: Bit 5 enables lockout; bit 4 picks threshold
// R02: Bit 3 enables backlight; else wait brightness write
// R03: Bit 2 adds set resistor to stored codes
// R04: Bit 1 takes boost frequency from pin
// R05: Bit 0 takes dimming frequency from pin
// R06: Bits 3:2 choose transition smoothing strength
// R07: Bits 1:0 choose input hysteresis resolution
// R08: Bits 6:4 choose ramp; zero is immediate
`timescale 1ns/1ns
`include "blcb_consts.vh"

module blcb_config_bank #(
  parameter CODE_WIDTH = 2
) (
  input  wire                  sys_clk,
  input  wire                  rst_n,
  input  wire                  wrEn,
  input  wire                  rdEn,
  input  wire [7:0]            addr,
  input  wire [7:0]            wrData,
  input  wire [CODE_WIDTH-1:0] codeA,
  input  wire [CODE_WIDTH-1:0] dimmingFreqCode,
  input  wire [CODE_WIDTH-1:0] freqSelectPin,
  output reg  [7:0]            rdData,
  output reg                   rdValid,
  output reg                   undervoltageLockoutEnable,
  output reg  [15:0]           lockoutThresholdMv,
  output reg                   backlightOn,
  output reg                   currentResistorEnable,
  output reg  [CODE_WIDTH-1:0] boostFreqSel,
  output reg  [CODE_WIDTH-1:0] dimmingFreqSel,
  output wire [1:0]            smoothLevel,
  output wire                  hystEnable,
  output wire [3:0]            hystResBits,
  output wire [2:0]            rampTimeSelect,
  output wire                  rampImmediate
);

  // ****************************************
  // Register storage
  // ****************************************
  reg  [7:0] protSrc_reg;
  reg  [7:0] trans_reg;
  reg        brightSeen_reg;

  wire wrProt   = wrEn && (addr == `BLCB_ADDR_PROT_SRC);
  wire wrTrans  = wrEn && (addr == `BLCB_ADDR_TRANSITION);
  wire wrBright = wrEn && (addr == `BLCB_ADDR_BRIGHTNESS);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protSrc_reg    <= `BLCB_RST_PROT_SRC;
      trans_reg      <= `BLCB_RST_TRANSITION;
      brightSeen_reg <= 1'b0;
    end else begin
      if (wrProt) begin
        protSrc_reg <= wrData & `BLCB_PROT_SRC_MASK;
      end
      if (wrTrans) begin
        trans_reg <= wrData;
      end
      // R02: brightness write releases
      if (wrBright) begin
        brightSeen_reg <= 1'b1;
      end
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData  <= 8'h00;
      rdValid <= 1'b0;
    end else begin
      rdValid <= rdEn;
      if (rdEn) begin
        if (addr == `BLCB_ADDR_PROT_SRC) begin
          rdData <= protSrc_reg;
        end else if (addr == `BLCB_ADDR_TRANSITION) begin
          rdData <= trans_reg;
        end else begin
          // Other addresses belong to neighbouring banks
          rdData <= 8'h00;
        end
      end
    end
  end

  // ****************************************
  // Frequency-select pin synchroniser
  // ****************************************
  // Bits may settle one edge apart while the pin moves, so one mixed
  // code can show for a cycle; accepted, the pin is a static strap
  wire [CODE_WIDTH-1:0] pinSync;

  genvar bitIdx;
  generate
    for (bitIdx = 0; bitIdx < CODE_WIDTH; bitIdx = bitIdx + 1) begin : gSync
      reg stage1_reg;
      reg stage2_reg;
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1_reg <= 1'b0;
          stage2_reg <= 1'b0;
        end else begin
          stage1_reg <= freqSelectPin[bitIdx];
          stage2_reg <= stage1_reg;
        end
      end
      // Only the second stage is read
      assign pinSync[bitIdx] = stage2_reg;
    end
  endgenerate

  // ****************************************
  // Protection and backlight outputs
  // ****************************************
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      undervoltageLockoutEnable <= 1'b0;
      lockoutThresholdMv        <= `BLCB_UVLO_LOW_MV;
      backlightOn               <= 1'b0;
      currentResistorEnable     <= 1'b0;
    end else begin
      // R01: lockout enable, threshold
      undervoltageLockoutEnable <= protSrc_reg[`BLCB_LOCKOUT_EN_BIT];
      lockoutThresholdMv <= protSrc_reg[`BLCB_LOCKOUT_TH_BIT] ?
                            `BLCB_UVLO_HIGH_MV : `BLCB_UVLO_LOW_MV;
      // R02: enable or host brightness
      backlightOn <= protSrc_reg[`BLCB_BL_EN_BIT] || brightSeen_reg;
      // R03: resistor plus stored codes
      currentResistorEnable <= protSrc_reg[`BLCB_CUR_RES_BIT];
    end
  end

  // ****************************************
  // Frequency source selection
  // ****************************************
  // Stored codes are already on sys_clk; only the pin needs the sync
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      boostFreqSel   <= {CODE_WIDTH{1'b0}};
      dimmingFreqSel <= {CODE_WIDTH{1'b0}};
    end else begin
      // R04: boost frequency source
      boostFreqSel <= protSrc_reg[`BLCB_BOOST_PIN_BIT] ?
                      pinSync : codeA;
      // R05: dimming frequency source
      dimmingFreqSel <= protSrc_reg[`BLCB_DIM_PIN_BIT] ?
                        pinSync : dimmingFreqCode;
    end
  end

  // ****************************************
  // Transition byte decode
  // ****************************************
  // R06: smoothing decode
  blcb_decode u_decode (
    .sys_clk       (sys_clk),
    .rst_n         (rst_n),
    .transByte     (trans_reg),
    .smoothLevel   (smoothLevel),
    .hystEnable    (hystEnable),
    .hystResBits   (hystResBits),
    .rampTime      (rampTimeSelect),
    .rampImmediate (rampImmediate)
  );

endmodule

// file: blcb_config_bank_tb_top.sv
/* Testbench for the configuration bank.
   Assumes the host model and checker files compile first. */
`timescale 1ns/1ns
module blcb_config_bank_tb_top;
  reg         sys_clk;
  reg         rst_n;
  reg  [1:0]  codeA, dimCode, pin;
  wire [1:0]  bSel, dSel, sm;
  wire [7:0]  addr, wrData, rdData;
  wire        wrEn, rdEn, rdV, uv, bl, iset, hEn, rImm;
  wire [15:0] thr;
  wire [3:0]  hRes;
  wire [2:0]  ramp;
  integer     err_total, checks;
  blcb_config_bank dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wrEn),
    .rdEn(rdEn), .addr(addr), .wrData(wrData), .codeA(codeA),
    .dimmingFreqCode(dimCode), .freqSelectPin(pin), .rdData(rdData),
    .rdValid(rdV), .undervoltageLockoutEnable(uv), .lockoutThresholdMv(thr),
    .backlightOn(bl), .currentResistorEnable(iset), .boostFreqSel(bSel),
    .dimmingFreqSel(dSel), .smoothLevel(sm), .hystEnable(hEn),
    .hystResBits(hRes), .rampTimeSelect(ramp), .rampImmediate(rImm));
  blcb_host host_u (.sys_clk(sys_clk), .rdData(rdData), .rdValid(rdV),
    .wrEn(wrEn), .rdEn(rdEn), .addr(addr), .wrData(wrData));
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  task chk(input string nm, input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] exp);
    reg [7:0] d;
    reg       v;
    begin
      host_u.rd(a, d, v);
      chk("rdValid", v, 1'b1);
      chk("rdData", d, exp);
      // Valid is a one-cycle pulse
      @(posedge sys_clk) #1;
      chk("rdValidOff", rdV, 1'b0);
    end
  endtask
  task wr1(input [7:0] a, input [7:0] d);
    begin
      host_u.wr(a, d);
      host_u.idle;
      repeat (2) @(posedge sys_clk) #1;
    end
  endtask
  task t_reset;
    begin
      chk("thr", thr, 16'h09C4);
      chk("bl", bl, 1'b0);
      chk("rampImm", rImm, 1'b1);
      rdchk(8'hA2, 8'h00);
      rdchk(8'hA3, 8'h00);
      $display("t_reset done");
    end
  endtask
  task t_prot;
    reg [7:0] v;
    integer   i;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        v = 32'h12_25_C8_37 >> (i * 8);
        pin = i;
        codeA = ~i;
        dimCode = i + 1;
        // Back to back, then a stray address that must not land
        host_u.wr(8'hA2, ~v);
        host_u.wr(8'hA2, v);
        wr1(8'hA5, 8'hFF);
        chk("uvloEn", uv, v[5]);
        chk("thr", thr, v[4] ? 16'h1450 : 16'h09C4);
        chk("bl", bl, v[3]);
        chk("iset", iset, v[2]);
        chk("boost", bSel, v[1] ? pin : codeA);
        chk("dim", dSel, v[0] ? pin : dimCode);
        rdchk(8'hA2, v);
      end
      $display("t_prot done");
    end
  endtask
  task t_trans;
    reg [7:0] v;
    integer   i;
    begin
      for (i = 0; i < 8; i = i + 1) begin
        v = {i[0], i[2:0], i[1:0], i[1:0]};
        wr1(8'hA3, v);
        chk("smooth", sm, v[3:2]);
        chk("hystEn", hEn, v[1:0] != 2'h0);
        chk("hystRes", hRes, v[1:0] == 2'h0 ? 4'h0 : v[1:0] == 2'h1 ?
          4'hD : v[1:0] == 2'h2 ? 4'hC : 4'h8);
        chk("ramp", ramp, v[6:4]);
        chk("rampImm", rImm, v[6:4] == 3'h0);
        rdchk(8'hA3, v);
      end
      $display("t_trans done");
    end
  endtask
  task t_bright;
    begin
      wr1(8'hA2, 8'h00);
      chk("bl", bl, 1'b0);
      wr1(8'h01, 8'h00);
      chk("bl", bl, 1'b1);
      rdchk(8'hA5, 8'h00);
      $display("t_bright done");
    end
  endtask
  // Mid-run reset must also clear the brightness-write latch
  task t_rerst;
    begin
      @(posedge sys_clk) #1;
      rst_n = 1'b0;
      repeat (2) @(posedge sys_clk) #1;
      rst_n = 1'b1;
      chk("uvloEn", uv, 1'b0);
      chk("bl", bl, 1'b0);
      chk("smooth", sm, 2'h0);
      chk("hystRes", hRes, 4'h0);
      chk("rampImm", rImm, 1'b1);
      rdchk(8'hA3, 8'h00);
      rdchk(8'hA2, 8'h00);
      chk("bl", bl, 1'b0);
      $display("t_rerst done");
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial begin
    err_total = 0;
    checks = 0;
    rst_n = 1'b0;
    codeA = 2'h0;
    dimCode = 2'h0;
    pin = 2'h0;
    repeat (3) @(posedge sys_clk) #1;
    rst_n = 1'b1;
    t_reset;
    t_prot;
    t_trans;
    t_bright;
    t_rerst;
    give_verdict;
  end
  // Whole run is about 120 cycles, well inside the 2000-cycle limit
  initial begin
    #100000;
    err_total = err_total + 1;
    give_verdict;
  end
endmodule
bind blcb_config_bank blcb_props #(.CODE_WIDTH(CODE_WIDTH)) props_u (
  .sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wrEn), .addr(addr),
  .wrData(wrData), .codeA(codeA), .dimmingFreqCode(dimmingFreqCode),
  .freqSelectPin(freqSelectPin),
  .undervoltageLockoutEnable(undervoltageLockoutEnable),
  .lockoutThresholdMv(lockoutThresholdMv), .backlightOn(backlightOn),
  .currentResistorEnable(currentResistorEnable),
  .boostFreqSel(boostFreqSel), .dimmingFreqSel(dimmingFreqSel),
  .smoothLevel(smoothLevel), .hystEnable(hystEnable),
  .hystResBits(hystResBits), .rampTimeSelect(rampTimeSelect),
  .rampImmediate(rampImmediate));

// file: blcb_consts.vh
/*
  Constants for the backlight configuration bank: register offsets, field
  positions, reset values and code meanings.
  Assumes inclusion by bare name from the bank's design files.
*/
`ifndef BLCB_CONSTS_VH
`define BLCB_CONSTS_VH

// ****************************************
// Register offsets
// ****************************************
`define BLCB_ADDR_PROT_SRC    8'hA2
`define BLCB_ADDR_TRANSITION  8'hA3
`define BLCB_ADDR_BRIGHTNESS  8'h01

// ****************************************
// Reset values
// ****************************************
`define BLCB_RST_PROT_SRC     8'h00
`define BLCB_RST_TRANSITION   8'h00

// ****************************************
// Protection and source byte fields
// ****************************************
`define BLCB_LOCKOUT_EN_BIT   5
`define BLCB_LOCKOUT_TH_BIT   4
`define BLCB_BL_EN_BIT        3
`define BLCB_CUR_RES_BIT      2
`define BLCB_BOOST_PIN_BIT    1
`define BLCB_DIM_PIN_BIT      0
`define BLCB_PROT_SRC_MASK    8'hFF

// ****************************************
// Transition byte fields
// ****************************************
`define BLCB_RAMP_MSB         6
`define BLCB_RAMP_LSB         4
`define BLCB_SMOOTH_MSB       3
`define BLCB_SMOOTH_LSB       2
`define BLCB_HYST_MSB         1
`define BLCB_HYST_LSB         0
`define BLCB_RAMP_IMMEDIATE   3'h0

// ****************************************
// Threshold in millivolts
// ****************************************
`define BLCB_UVLO_LOW_MV      16'h09C4
`define BLCB_UVLO_HIGH_MV     16'h1450

// ****************************************
// Hysteresis resolution codes
// ****************************************
`define BLCB_HYST_OFF         2'h0
`define BLCB_HYST_RES13       2'h1
`define BLCB_HYST_RES12       2'h2
`define BLCB_HYST_RES8        2'h3
`define BLCB_RES_NONE         4'h0
`define BLCB_RES_13           4'hD
`define BLCB_RES_12           4'hC
`define BLCB_RES_8            4'h8

`endif

// file: blcb_decode.v
/*
  Decodes the transition byte into registered smoothing and hysteresis
  controls.
  Assumes the byte comes from logic on the same clock.
*/
`timescale 1ns/1ns
`include "blcb_consts.vh"

module blcb_decode (
  input  wire       sys_clk,
  input  wire       rst_n,
  input  wire [7:0] transByte,
  output reg  [1:0] smoothLevel,
  output reg        hystEnable,
  output reg  [3:0] hystResBits,
  output reg  [2:0] rampTime,
  output reg        rampImmediate
);

  reg [3:0] resNext;
  wire [1:0] hystCode;

  assign hystCode = transByte[`BLCB_HYST_MSB:`BLCB_HYST_LSB];

  // R07: hysteresis resolution
  always @* begin
    case (hystCode)
      `BLCB_HYST_RES13: resNext = `BLCB_RES_13;
      `BLCB_HYST_RES12: resNext = `BLCB_RES_12;
      `BLCB_HYST_RES8:  resNext = `BLCB_RES_8;
      default:          resNext = `BLCB_RES_NONE;
    endcase
  end

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      smoothLevel   <= 2'h0;
      hystEnable    <= 1'b0;
      hystResBits   <= 4'h0;
      rampTime      <= 3'h0;
      rampImmediate <= 1'b1;
    end else begin
      // R06: smoothing strength
      smoothLevel   <= transByte[`BLCB_SMOOTH_MSB:`BLCB_SMOOTH_LSB];
      hystEnable    <= (hystCode != `BLCB_HYST_OFF);
      hystResBits   <= resNext;
      // R08: ramp time code
      rampTime      <= transByte[`BLCB_RAMP_MSB:`BLCB_RAMP_LSB];
      rampImmediate <= (transByte[`BLCB_RAMP_MSB:`BLCB_RAMP_LSB]
                        == `BLCB_RAMP_IMMEDIATE);
    end
  end

endmodule

// file: blcb_host.sv
/* Host model: byte writes and reads into the bank.
   Assumes callers end each write burst with idle. */
`timescale 1ns/1ns
module blcb_host (
  input  wire       sys_clk,
  input  wire [7:0] rdData,
  input  wire       rdValid,
  output reg        wrEn,
  output reg        rdEn,
  output reg  [7:0] addr,
  output reg  [7:0] wrData
);
  initial begin
    wrEn = 1'b0;
    rdEn = 1'b0;
    addr = 8'h00;
    wrData = 8'h00;
  end
  // Strobe stays up so writes can run back to back
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk) #1;
      wrEn = 1'b1;
      addr = a;
      wrData = d;
    end
  endtask
  // Released data inverted so stale bytes never match
  task idle;
    begin
      @(posedge sys_clk) #1;
      wrEn = 1'b0;
      wrData = ~wrData;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d, output v);
    begin
      @(posedge sys_clk) #1;
      rdEn = 1'b1;
      addr = a;
      @(posedge sys_clk) #1;
      rdEn = 1'b0;
      d = rdData;
      v = rdValid;
    end
  endtask
endmodule

// file: blcb_props.sv
/* Port checker for the configuration bank.
   Assumes a bind onto blcb_config_bank, one clock. */
`timescale 1ns/1ns
module blcb_props #(
  parameter CODE_WIDTH = 2
) (
  input wire                  sys_clk,
  input wire                  rst_n,
  input wire                  wrEn,
  input wire [7:0]            addr,
  input wire [7:0]            wrData,
  input wire [CODE_WIDTH-1:0] codeA,
  input wire [CODE_WIDTH-1:0] dimmingFreqCode,
  input wire [CODE_WIDTH-1:0] freqSelectPin,
  input wire                  undervoltageLockoutEnable,
  input wire [15:0]           lockoutThresholdMv,
  input wire                  backlightOn,
  input wire                  currentResistorEnable,
  input wire [CODE_WIDTH-1:0] boostFreqSel,
  input wire [CODE_WIDTH-1:0] dimmingFreqSel,
  input wire [1:0]            smoothLevel,
  input wire                  hystEnable,
  input wire [3:0]            hystResBits,
  input wire [2:0]            rampTimeSelect,
  input wire                  rampImmediate
);
  reg  [7:0] d1;
  reg  [7:0] d2;
  wire       wA2 = wrEn && addr == 8'hA2;
  wire       wA3 = wrEn && addr == 8'hA3;
  // Write data two edges back, when outputs follow
  always @(posedge sys_clk) begin
    d1 <= wrData;
    d2 <= d1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s2; wA2 ##1 !wA2; endsequence
  sequence s3; wA3 ##1 !wA3; endsequence
  AST_LOCKOUT_EN: assert property (
    s2 |=> undervoltageLockoutEnable == d2[5]) else $error("lockout en");
  AST_LOCKOUT_TH: assert property (
    s2 |=> lockoutThresholdMv == (d2[4] ? 16'h1450 : 16'h09C4))
    else $error("threshold");
  AST_BL_BIT: assert property (
    wA2 && wrData[3] ##1 !wA2 |=> backlightOn) else $error("bl bit");
  AST_BL_WR: assert property (
    wrEn && addr == 8'h01 |-> ##2 backlightOn) else $error("bl write");
  AST_ISET: assert property (
    s2 |=> currentResistorEnable == d2[2]) else $error("resistor");
  AST_BOOST: assert property (
    s2 |=> boostFreqSel ==
    (d2[1] ? $past(freqSelectPin, 3) : $past(codeA)))
    else $error("boost sel");
  AST_DIM: assert property (
    s2 |=> dimmingFreqSel ==
    (d2[0] ? $past(freqSelectPin, 3) : $past(dimmingFreqCode)))
    else $error("dim sel");
  AST_SMOOTH: assert property (
    s3 |=> smoothLevel == d2[3:2]) else $error("smooth");
  AST_HYST: assert property (
    s3 |=> hystEnable == (d2[1:0] != 2'h0) && hystResBits ==
    (d2[1:0] == 2'h0 ? 4'h0 : d2[1:0] == 2'h1 ? 4'hD :
    d2[1:0] == 2'h2 ? 4'hC : 4'h8)) else $error("hysteresis");
  AST_RAMP: assert property (
    s3 |=> rampTimeSelect == d2[6:4] && rampImmediate == (d2[6:4] == 3'h0))
    else $error("ramp");
  C_A2: cover property (s2);
  C_A3: cover property (s3);
  C_BRIGHT: cover property (wrEn && addr == 8'h01 ##2 backlightOn);
endmodule
